// >>> rtl/dma_pkg.sv
// Package with constants and carriers for debug master arbitration and debug registers
package dma_pkg;
   localparam logic [17:0] DMA_CCR_HOLD_ADDR = 18'h3ff06;
   localparam logic [17:0] DMA_PAGE_IDX_ADDR = 18'h3ff08;
   localparam logic [7:0] DMA_CCR_RESET_SSC = 8'hd8;
   localparam logic [7:0] DMA_CCR_RESET_OTHER = 8'h00;
   localparam logic [7:0] DMA_PAGE_IDX_RESET = 8'h00;
   localparam int DMA_PAGE_EN_BIT = 7;
   localparam logic [7:0] DMA_PAGE_IDX_MASK = 8'h8f;
   localparam int DMA_STALL_LIMIT = 128;
   localparam int DMA_CNT_W = 8;

   typedef struct packed {
      logic req;
      logic [17:0] addr;
      logic globalAcc;
   } dma_req_s;

   typedef enum logic [1:0] {
      DMA_IDLE = 2'b00,
      DMA_CORE = 2'b01,
      DMA_DRAIN = 2'b11,
      DMA_DEBUG = 2'b10
   } dma_state_e;
endpackage

// >>> rtl/dma_debug_arb.sv
// Target bus arbiter between core and debug unit, with the debug holding registers
`timescale 1ns/1ps
module dma_debug_arb
   import dma_pkg::*;
#(
   parameter int STALL_LIMIT = DMA_STALL_LIMIT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic specialSingleChip,
   input wire logic secured,
   input wire logic coreReq,
   input wire logic coreOpDone,
   input wire logic dbgReq,
   input wire logic dbgGlobal,
   input wire logic dbgRegCmd,
   input wire logic dbgWrite,
   input wire logic [17:0] dbgAddr,
   input wire logic [7:0] dbgWdata,
   input wire logic dbgActivate,
   input wire logic [7:0] coreCcr,
   output logic coreGrant_ff,
   output logic dbgGrant_ff,
   output logic coreStall_ff,
   output logic [7:0] dbgRdata_ff,
   output logic [7:0] restoreCcr_ff,
   output logic pageEnable_ff,
   output logic [3:0] pageSelect_ff,
   output logic dbgGlobalOut_ff,
   output logic irqOut_ff
);
   // ****************************************
   // Arbitration
   // ****************************************
   dma_state_e state_ff;
   dma_state_e nxt_state;
   logic [DMA_CNT_W-1:0] stallCnt_ff;
   logic strapSeen_ff;
   logic [7:0] ccrHold_ff;
   logic [7:0] pageIdx_ff;
   logic regHit;
   logic ccrHit;
   logic pageHit;
   logic escalate;

   assign escalate = (stallCnt_ff >= DMA_CNT_W'(STALL_LIMIT));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         DMA_IDLE: begin
            if (coreReq) begin
               nxt_state = DMA_CORE;
            end else if (dbgReq) begin
               nxt_state = DMA_DEBUG;
            end
         end
         DMA_CORE: begin
            if (dbgReq && escalate) begin
               nxt_state = coreOpDone ? DMA_DEBUG : DMA_DRAIN;
            end else if (!coreReq) begin
               nxt_state = DMA_IDLE;
            end
         end
         DMA_DRAIN: begin
            if (coreOpDone) begin
               nxt_state = DMA_DEBUG;
            end
         end
         DMA_DEBUG: begin
            if (!dbgReq) begin
               nxt_state = DMA_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= DMA_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // One-hot grants from the state keep the two masters exclusive
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         coreGrant_ff <= 1'b0;
         dbgGrant_ff <= 1'b0;
         coreStall_ff <= 1'b0;
      end else begin
         coreGrant_ff <= (nxt_state == DMA_CORE) || (nxt_state == DMA_DRAIN);
         dbgGrant_ff <= (nxt_state == DMA_DEBUG);
         coreStall_ff <= (nxt_state == DMA_DEBUG) && coreReq;
      end
   end

   // Counts only a continuous wait
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stallCnt_ff <= '0;
      end else if (!dbgReq || dbgGrant_ff) begin
         stallCnt_ff <= '0;
      end else if (!escalate) begin
         stallCnt_ff <= stallCnt_ff + DMA_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqOut_ff <= 1'b0;
      end else begin
         irqOut_ff <= 1'b0;
      end
   end

   // ****************************************
   // Debug registers
   // ****************************************
   // Full address compare, shared by both register decodes
   function automatic logic addrIs(input logic [17:0] a, input logic [17:0] t);
      return a == t;
   endfunction

   assign regHit = dbgReq && dbgGrant_ff && !secured;
   assign ccrHit = regHit && addrIs(dbgAddr, DMA_CCR_HOLD_ADDR);
   assign pageHit = regHit && addrIs(dbgAddr, DMA_PAGE_IDX_ADDR);

   // Mode strap sampled after release, since async reset takes constants only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strapSeen_ff <= 1'b0;
         ccrHold_ff <= DMA_CCR_RESET_OTHER;
      end else if (!strapSeen_ff) begin
         strapSeen_ff <= 1'b1;
         ccrHold_ff <= specialSingleChip ? DMA_CCR_RESET_SSC : DMA_CCR_RESET_OTHER;
      end else if (dbgActivate) begin
         ccrHold_ff <= coreCcr;
      end else if (ccrHit && dbgWrite) begin
         ccrHold_ff <= dbgWdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pageIdx_ff <= DMA_PAGE_IDX_RESET;
      end else if (pageHit && dbgWrite) begin
         pageIdx_ff <= dbgWdata & DMA_PAGE_IDX_MASK;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dbgRdata_ff <= 8'h00;
         restoreCcr_ff <= DMA_CCR_RESET_OTHER;
         pageEnable_ff <= 1'b0;
         pageSelect_ff <= 4'h0;
         dbgGlobalOut_ff <= 1'b0;
      end else begin
         dbgRdata_ff <= ccrHit ? ccrHold_ff : (pageHit ? pageIdx_ff : 8'h00);
         restoreCcr_ff <= ccrHold_ff;
         pageEnable_ff <= pageIdx_ff[DMA_PAGE_EN_BIT];
         pageSelect_ff <= pageIdx_ff[3:0];
         dbgGlobalOut_ff <= dbgGlobal && !dbgRegCmd;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_excl;
      @(posedge clk) disable iff (!reset_n) !(coreGrant_ff && dbgGrant_ff);
   endproperty
   a_excl: assert property (p_excl) else $error("both masters granted");

   property p_core_first;
      @(posedge clk) disable iff (!reset_n)
         (state_ff == DMA_IDLE && coreReq && dbgReq) |=> coreGrant_ff && !dbgGrant_ff;
   endproperty
   a_core_first: assert property (p_core_first) else $error("core lost contention");

   property p_escalate;
      @(posedge clk) disable iff (!reset_n)
         (dbgReq && state_ff == DMA_CORE && escalate && coreOpDone) |=> dbgGrant_ff;
   endproperty
   a_escalate: assert property (p_escalate) else $error("no escalation");

   sequence s_draining;
      state_ff == DMA_DRAIN && !coreOpDone;
   endsequence
   property p_drain;
      @(posedge clk) disable iff (!reset_n) s_draining |=> coreGrant_ff && !dbgGrant_ff;
   endproperty
   a_drain: assert property (p_drain) else $error("core cut mid operation");

   property p_noirq;
      @(posedge clk) disable iff (!reset_n) !irqOut_ff;
   endproperty
   a_noirq: assert property (p_noirq) else $error("interrupt raised");

   property p_save;
      @(posedge clk) disable iff (!reset_n)
         (strapSeen_ff && dbgActivate) |=> ccrHold_ff == $past(coreCcr);
   endproperty
   a_save: assert property (p_save) else $error("ccr not saved");

   property p_secure;
      @(posedge clk) disable iff (!reset_n) secured |=> dbgRdata_ff == 8'h00;
   endproperty
   a_secure: assert property (p_secure) else $error("read while secured");

   property p_resv;
      @(posedge clk) disable iff (!reset_n) pageIdx_ff[6:4] == 3'b000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved page bits set");

   property p_noglobal;
      @(posedge clk) disable iff (!reset_n) dbgRegCmd |=> !dbgGlobalOut_ff;
   endproperty
   a_noglobal: assert property (p_noglobal) else $error("global via reg cmd");

   property p_cntclr;
      @(posedge clk) disable iff (!reset_n) !dbgReq |=> stallCnt_ff == '0;
   endproperty
   a_cntclr: assert property (p_cntclr) else $error("stall count kept");
endmodule // dma_debug_arb

// >>> bench/dma_core_model.sv
// Core master model that finishes its operations while it owns the bus
`timescale 1ns/1ps
module dma_core_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic granted,
   input wire logic slow,
   output logic opDone_ff
);
   logic [2:0] cnt_ff;
   // Slow core ends an operation only every eighth cycle
   always_ff @(negedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 3'h0;
         opDone_ff <= 1'b0;
      end else begin
         cnt_ff <= granted ? cnt_ff + 3'h1 : 3'h0;
         opDone_ff <= granted && (slow ? cnt_ff == 3'h5 : 1'b1);
      end
   end
endmodule // dma_core_model

// >>> bench/dma_debug_arb_tb.sv
// Self-checking bench for the debug master arbiter and holding registers
`timescale 1ns/1ps
module dma_debug_arb_tb;
   import dma_pkg::*;
   localparam int LIM = 8;
   logic clk = 0, reset_n = 0, ssc = 1, secured = 0, coreReq = 0, dbgReq = 0;
   logic dbgGlobal = 0, dbgRegCmd = 0, dbgWrite = 0, dbgActivate = 0, slow = 0;
   logic coreOpDone, coreGrant, dbgGrant, coreStall, pageEn, globOut, irq;
   logic [17:0] dbgAddr = 18'h0;
   logic [7:0] dbgWdata = 8'h0, coreCcr = 8'h0, rnd = 8'h29, rd, rdata, restore, val;
   logic [3:0] pageSel;
   int errors = 0, n_compared = 0;
   dma_debug_arb #(.STALL_LIMIT(LIM)) uut (.clk(clk), .reset_n(reset_n),
      .specialSingleChip(ssc), .secured(secured), .coreReq(coreReq),
      .coreOpDone(coreOpDone), .dbgReq(dbgReq), .dbgGlobal(dbgGlobal),
      .dbgRegCmd(dbgRegCmd), .dbgWrite(dbgWrite), .dbgAddr(dbgAddr),
      .dbgWdata(dbgWdata), .dbgActivate(dbgActivate), .coreCcr(coreCcr),
      .coreGrant_ff(coreGrant), .dbgGrant_ff(dbgGrant), .coreStall_ff(coreStall),
      .dbgRdata_ff(rdata), .restoreCcr_ff(restore), .pageEnable_ff(pageEn),
      .pageSelect_ff(pageSel), .dbgGlobalOut_ff(globOut), .irqOut_ff(irq));
   dma_core_model core (.clk(clk), .reset_n(reset_n), .granted(coreGrant),
      .slow(slow), .opDone_ff(coreOpDone));
   initial forever #10 clk = ~clk;
   // ********
   // Helpers
   // ********
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] expPage(input logic [7:0] d);
      return {d[7], 3'h0, d[3:0]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic resetDut(input logic mode);
      reset_n = 0;
      ssc = mode;
      step(4);
      reset_n = 1;
      step(3);
   endtask
   // Single debug-unit access; rd holds what the read returned
   task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d);
      int i;
      dbgReq = 1;
      dbgRegCmd = 1;
      dbgWrite = w;
      dbgAddr = a;
      dbgWdata = d;
      for (i = 0; i < 20 && dbgGrant !== 1'b1; i++) @(negedge clk);
      step(1);
      rd = rdata;
      dbgReq = 0;
      dbgWrite = 0;
      step(2);
   endtask
   always @(negedge clk) begin
      if (reset_n) begin
         chk("oneMaster", coreGrant & dbgGrant, 8'h0);
         chk("irq", irq, 8'h0);
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      results();
   end
   // ********
   // Scenarios
   // ********
   initial begin
      step(1);
      resetDut(1);
      acc(0, DMA_CCR_HOLD_ADDR, 8'h0);
      chk("ccrSsc", rd, 8'hd8);
      acc(0, DMA_PAGE_IDX_ADDR, 8'h0);
      chk("pageRst", rd, 8'h0);
      resetDut(0);
      acc(0, DMA_CCR_HOLD_ADDR, 8'h0);
      chk("ccrOther", rd, 8'h0);
      for (int i = 0; i < 6; i++) begin
         val = (i == 0) ? 8'hff : rnd;
         acc(1, DMA_CCR_HOLD_ADDR, val);
         chk("restore", restore, val);
         acc(0, DMA_CCR_HOLD_ADDR, 8'h0);
         chk("ccrRead", rd, val);
         acc(1, DMA_PAGE_IDX_ADDR, ~val);
         chk("pageEn", pageEn, val[7] ? 8'h0 : 8'h1);
         chk("pageSel", pageSel, {4'h0, ~val[3:0]});
         acc(0, DMA_PAGE_IDX_ADDR, 8'h0);
         chk("pageRead", rd, expPage(~val));
         if (i > 0) rnd = lfsr(rnd);
      end
      secured = 1;
      acc(1, DMA_CCR_HOLD_ADDR, ~val);
      acc(0, DMA_CCR_HOLD_ADDR, 8'h0);
      chk("securedRead", rd, 8'h0);
      chk("securedWrite", restore, val);
      secured = 0;
      dbgGlobal = 1;
      step(2);
      chk("globalReg", globOut, 8'h0);
      dbgRegCmd = 0;
      step(2);
      chk("globalMem", globOut, 8'h1);
      dbgGlobal = 0;
      coreCcr = lfsr(rnd);
      dbgActivate = 1;
      step(1);
      dbgActivate = 0;
      step(2);
      chk("activate", restore, coreCcr);
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         coreReq = 1;
         dbgReq = 1;
         step(2);
         chk("coreWins", coreGrant, 8'h1);
         step(LIM - 3);
         chk("dbgHeld", dbgGrant, 8'h0);
         for (int i = 0; i < 20 && dbgGrant !== 1'b1; i++) @(negedge clk);
         chk("dbgEsc", dbgGrant, 8'h1);
         chk("coreStall", coreStall, 8'h1);
         coreReq = 0;
         dbgReq = 0;
         step(3);
      end
      results();
   end
endmodule // dma_debug_arb_tb
